// ===== inc/eacs_pkg.sv
package eacs_pkg;
   localparam logic [1:0] EACS_PAGE_WIN_HI = 2'b10;
   localparam logic [1:0] EACS_BLK_LOW = 2'b00;
   localparam logic [1:0] EACS_BLK_MID = 2'b01;
   localparam logic [1:0] EACS_BLK_TOP = 2'b11;
   localparam logic [5:0] EACS_XA_LOW = 6'h3d;
   localparam logic [5:0] EACS_XA_MID = 6'h3e;
   localparam logic [5:0] EACS_XA_TOP = 6'h3f;
   localparam logic [5:0] EACS_INT_BOUND_00 = 6'h38;
   localparam logic [5:0] EACS_INT_BOUND_01 = 6'h30;
   localparam logic [5:0] EACS_INT_BOUND_10 = 6'h20;
   localparam logic [5:0] EACS_INT_BOUND_11 = 6'h00;
   localparam logic [5:0] EACS_PORT_RST = 6'h00;
   typedef enum logic [1:0] {
      EACS_ALLOC_0K = 2'h0,
      EACS_ALLOC_16K = 2'h1,
      EACS_ALLOC_48K = 2'h2,
      EACS_ALLOC_64K = 2'h3
   } eacs_alloc_type;
   typedef struct packed {
      logic [15:0] addr;
      logic [5:0] page;
      logic ext_space;
   } eacs_access_type;
endpackage

// ===== design/eacs_decode.sv
// Summary of operation
// - Active window accesses drive the page index on the address lines.
// - Outside the window the code is 0x3d, 0x3e or 0x3f per block.
// - Address lines and select reach pins only when enabled and expanded.
// - At 0K the select is high for low blocks, low for window and top.
// - At 16K the select is low only for the top block.
// - At 48K: top, middle if upper-half bit 0, internal window; never low.
// - At 64K: low blocks if upper-half bit 0, internal window and top.
// - The select is active low and the upper-half bit acts at 48K/64K.
// - A window access is internal at or above the partition boundary.
// - Port K bit 7 carries the emulation select only when active.
// - Bit 6 select asserts when emulation select idles and space external.
`timescale 1ns/1ps
module eacs_decode (
   input wire logic clk_sys_i,
   input wire logic srst_i,
   input eacs_pkg::eacs_access_type access_i,
   input wire logic expanded_mode_i,
   input wire logic emulation_port_k_enable_i,
   input wire logic rom_upper_half_only_i,
   input wire logic [1:0] paging_partition_select_i,
   input eacs_pkg::eacs_alloc_type alloc_i,
   input wire logic [7:0] gpio_out_i,
   output logic [5:0] extended_address_high_o,
   output logic [7:0] port_k_o,
   output logic emulation_chip_select_n_o,
   output logic external_chip_select_n_o
);
   import eacs_pkg::*;

   // Registered outputs
   logic [7:0] port_k_r;
   logic [5:0] xa_r;
   logic ecs_n_r;
   logic xcs_n_r;

   // Fields of the current access
   logic [15:0] acc_addr;
   logic [5:0] acc_page;
   logic acc_ext;
   logic [1:0] blk;

   assign acc_addr = access_i.addr;
   assign acc_page = access_i.page;
   assign acc_ext = access_i.ext_space;
   assign blk = acc_addr[15:14];

   // One flag per 16K block of the physical map
   logic blk_low;
   logic blk_mid;
   logic in_win;
   logic blk_top;

   assign blk_low = (blk == EACS_BLK_LOW);
   assign blk_mid = (blk == EACS_BLK_MID);
   assign in_win = (blk == EACS_PAGE_WIN_HI);
   assign blk_top = (blk == EACS_BLK_TOP);

   // Decode takes effect only in expanded mode with emulation on
   logic active;

   assign active = emulation_port_k_enable_i & expanded_mode_i;

   // Partition setting, one flag per code except 2'b11
   logic part_00;
   logic part_01;
   logic part_10;

   assign part_00 = (paging_partition_select_i == 2'b00);
   assign part_01 = (paging_partition_select_i == 2'b01);
   assign part_10 = (paging_partition_select_i == 2'b10);

   // Lowest page that the window treats as internal
   logic [5:0] bound;

   assign bound = part_00 ? EACS_INT_BOUND_00 :
      part_01 ? EACS_INT_BOUND_01 :
      part_10 ? EACS_INT_BOUND_10 :
      EACS_INT_BOUND_11;

   // Window access at or above the boundary is internal
   logic page_hi;
   logic win_int;

   assign page_hi = (acc_page >= bound);
   assign win_int = in_win & page_hi;

   // Upper-half bit, used by the 48K and 64K terms only
   logic rom_lo;

   assign rom_lo = ~rom_upper_half_only_i;

   // Fixed code outside the window
   logic [5:0] xa_fixed;

   assign xa_fixed = blk_low ? EACS_XA_LOW :
      blk_mid ? EACS_XA_MID :
      EACS_XA_TOP;

   // Page index inside the window
   logic [5:0] xa_nxt;

   assign xa_nxt = in_win ? acc_page : xa_fixed;

   // Select term for each allocation
   logic sel_0k;
   logic sel_16k;
   logic sel_48k;
   logic sel_64k;

   // Small sizes ignore the upper-half bit
   assign sel_0k = in_win | blk_top;
   assign sel_16k = blk_top;
   assign sel_48k = blk_top | win_int |
      (blk_mid & rom_lo);
   assign sel_64k = blk_top | win_int |
      ((blk_low | blk_mid) & rom_lo);

   // Pick the term of the allocated size
   logic sel;

   always_comb begin
      sel = 1'b0;
      case (alloc_i)
         EACS_ALLOC_0K: begin
            sel = sel_0k;
         end
         EACS_ALLOC_16K: begin
            sel = sel_16k;
         end
         EACS_ALLOC_48K: begin
            sel = sel_48k;
         end
         EACS_ALLOC_64K: begin
            sel = sel_64k;
         end
         default: begin
            sel = 1'b0;
         end
      endcase
   end

   // Emulation select wanted, and external select in its absence
   logic ecs_on;
   logic xcs_on;

   assign ecs_on = active & sel;
   assign xcs_on = active & ~ecs_on & acc_ext;

   // Both chip selects are active low and idle high when off
   logic ecs_n_nxt;
   logic xcs_n_nxt;

   assign ecs_n_nxt = ~ecs_on;
   assign xcs_n_nxt = ~xcs_on;

   // Extended address lines rest at zero when off
   logic [5:0] xa_out_nxt;

   assign xa_out_nxt = active ? xa_nxt : EACS_PORT_RST;

   // Port K carries the emulation signals only when active
   logic [7:0] pk_emu;
   logic [7:0] pk_nxt;

   assign pk_emu = {ecs_n_nxt, xcs_n_nxt, xa_nxt};

   // One pin mux per port K bit
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi = gi + 1) begin : g_pk_bit
         // GPIO value on the pin whenever decode is off
         assign pk_nxt[gi] = active ? pk_emu[gi] :
            gpio_out_i[gi];
      end
   endgenerate

   // Output registers, one per output port

   // Port K pin register, idle pattern in reset
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         port_k_r <= {2'b11, EACS_PORT_RST};
      end else begin
         port_k_r <= pk_nxt;
      end
   end

   // Extended address register
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         xa_r <= EACS_PORT_RST;
      end else begin
         xa_r <= xa_out_nxt;
      end
   end

   // Emulation select register
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         ecs_n_r <= 1'b1;
      end else begin
         ecs_n_r <= ecs_n_nxt;
      end
   end

   // External select register
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         xcs_n_r <= 1'b1;
      end else begin
         xcs_n_r <= xcs_n_nxt;
      end
   end

   // Ports straight from the registers
   assign extended_address_high_o = xa_r;
   assign port_k_o = port_k_r;
   assign emulation_chip_select_n_o = ecs_n_r;
   assign external_chip_select_n_o = xcs_n_r;
endmodule // eacs_decode

// ===== verification/eacs_emu_mem.sv
`timescale 1ns/1ps
module eacs_emu_mem(input wire logic clk_sys_i, cs_n_i,
   input wire logic [5:0] xa_i, output logic [5:0] seen_o);
   always_ff @(posedge clk_sys_i) if (!cs_n_i) seen_o <= xa_i;
endmodule // eacs_emu_mem

// ===== verification/eacs_decode_asserts.sv
`timescale 1ns/1ps
module eacs_decode_asserts(input wire logic clk_sys_i, srst_i, expanded_mode_i,
   emulation_port_k_enable_i, emulation_chip_select_n_o,
   external_chip_select_n_o, input eacs_pkg::eacs_access_type access_i,
   input eacs_pkg::eacs_alloc_type alloc_i,
   input wire logic [5:0] extended_address_high_o);
   logic r;
   wire a = expanded_mode_i & emulation_port_k_enable_i;
   wire e = emulation_chip_select_n_o;
   wire [5:0] x = extended_address_high_o;
   wire [1:0] b = access_i.addr[15:14];
   always_ff @(posedge clk_sys_i) r <= srst_i;
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (srst_i || r);
   chk_xa_page: assert property (
      a && b == 2'h2 |=> x == $past(access_i.page)) else $error("bad xa");
   chk_xa_fixed: assert property (
      a && b != 2'h2 |=> x == 6'h3d + $past(b) - &$past(b)) else $error("bad xa");
   chk_off_idle: assert property (
      !a |=> x == 6'h00 && e) else $error("not idle");
   chk_xcs_excl: assert property (
      !e |-> external_chip_select_n_o) else $error("both selects");
   chk_ecs_zero: assert property (
      a && alloc_i == 2'h0 |=> e == !$past(b[1])) else $error("bad ecs");
   chk_ecs_16k: assert property (
      a && alloc_i == 2'h1 |=> e == ($past(b) != 2'h3)) else $error("bad ecs");
   chk_ecs_top: assert property (
      a && b == 2'h3 |=> !e) else $error("bad ecs");
   chk_ecs_low48: assert property (
      a && alloc_i == 2'h2 && b == 2'h0 |=> e) else $error("bad ecs");
endmodule // eacs_decode_asserts
bind eacs_decode eacs_decode_asserts u_chk(.*);

// ===== verification/test_extended_address_chip_select.sv
`timescale 1ns/1ps
module test_extended_address_chip_select;
   import eacs_pkg::*;
   logic clk_sys_i = 1'b0, srst_i = 1'b1, expanded_mode_i = 1'b1;
   logic emulation_port_k_enable_i = 1'b1, rom_upper_half_only_i = 1'b0;
   logic emulation_chip_select_n_o, external_chip_select_n_o;
   logic [1:0] paging_partition_select_i = 2'h0;
   logic [5:0] extended_address_high_o, seen;
   logic [7:0] port_k_o, gpio_out_i = 8'ha5;
   eacs_access_type access_i = '0;
   eacs_alloc_type alloc_i = EACS_ALLOC_0K;
   int error_cnt = 0, total_checks = 0;
   logic ext_tb = 1'b1, act_tb, xcs_exp;
   logic [7:0] pk_exp;
   eacs_decode DUT(.*);
   eacs_emu_mem u_mem(.clk_sys_i(clk_sys_i), .cs_n_i(emulation_chip_select_n_o),
      .xa_i(extended_address_high_o), .seen_o(seen));
   initial forever #10 clk_sys_i = ~clk_sys_i;
   task automatic check(input logic [7:0] v, w);
      total_checks++;
      if (v !== w) begin
         error_cnt++;
         $display("unexpected at %0t: %h vs %h", $time, v, w);
      end
   endtask
   task automatic print_verdict;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // Mode is {upper half bit, allocation}; expect is {select, xa}
   task automatic go(input logic [15:0] ad, input logic [5:0] pg,
      input logic [2:0] md, input logic [6:0] ex);
      @(posedge clk_sys_i);
      access_i <= '{ad, pg, ext_tb};
      rom_upper_half_only_i <= md[2];
      alloc_i <= eacs_alloc_type'(md[1:0]);
      @(posedge clk_sys_i);
      #1 check({1'b0, emulation_chip_select_n_o, extended_address_high_o},
         {1'b0, ex});
      act_tb = expanded_mode_i & emulation_port_k_enable_i;
      xcs_exp = ~(act_tb & ex[6] & ext_tb);
      pk_exp = act_tb ? {ex[6], xcs_exp, ex[5:0]} : gpio_out_i;
      check({7'h0, external_chip_select_n_o}, {7'h0, xcs_exp});
      check(port_k_o, pk_exp);
   endtask
   initial begin
      repeat (3) @(posedge clk_sys_i);
      srst_i <= 1'b0;
      go(16'h0000, 6'h05, 3'h0, 7'h7d);
      go(16'h8000, 6'h05, 3'h0, 7'h05);
      go(16'h8000, 6'h05, 3'h1, 7'h45);
      go(16'h0000, 6'h05, 3'h2, 7'h7d);
      go(16'h4000, 6'h05, 3'h2, 7'h3e);
      go(16'h7fff, 6'h05, 3'h6, 7'h7e);
      go(16'h9000, 6'h37, 3'h2, 7'h77);
      go(16'hbfff, 6'h38, 3'h3, 7'h38);
      go(16'h3fff, 6'h05, 3'h7, 7'h7d);
      paging_partition_select_i <= 2'h1;
      go(16'h8000, 6'h30, 3'h2, 7'h30);
      go(16'h8000, 6'h2f, 3'h2, 7'h6f);
      paging_partition_select_i <= 2'h2;
      go(16'ha000, 6'h1f, 3'h3, 7'h5f);
      paging_partition_select_i <= 2'h3;
      go(16'h8000, 6'h00, 3'h2, 7'h00);
      ext_tb = 1'b0;
      go(16'h0000, 6'h05, 3'h0, 7'h7d);
      go(16'hc000, 6'h05, 3'h7, 7'h3f);
      emulation_port_k_enable_i <= 1'b0;
      go(16'h8000, 6'h05, 3'h3, 7'h40);
      check(port_k_o, 8'ha5);
      emulation_port_k_enable_i <= 1'b1;
      expanded_mode_i <= 1'b0;
      go(16'hc000, 6'h05, 3'h0, 7'h40);
      check({2'h0, seen}, 8'h3f);
      srst_i <= 1'b1;
      @(posedge clk_sys_i);
      srst_i <= 1'b0;
      #1 check(port_k_o, 8'hc0);
      print_verdict;
   end
   initial begin
      #5000;
      error_cnt++;
      print_verdict;
   end
endmodule // test_extended_address_chip_select
